// *** hdl/rcd_pkg.sv ***
package rcd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the Wishbone bus.
    localparam logic [3:0] ADDR_CONTROL  = 4'h0;
    localparam logic [3:0] ADDR_DIVISOR  = 4'h4;
    localparam logic [3:0] ADDR_TRIM     = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register field positions.
    localparam int CTL_ENABLE_BIT  = 15;
    localparam int CTL_PIN_BIT     = 12;
    localparam int CTL_UPDATE_BIT  = 9;
    localparam int CTL_ACTIVE_BIT  = 8;
    localparam int CTL_SEL_LSB     = 0;
    localparam int SEL_W           = 4;

    // Divisor and trim field layout.
    localparam int DIV_W           = 15;
    localparam int TRIM_W          = 9;
    localparam int TRIM_LSB        = 7;

    // Reset values.
    localparam logic [14:0] DIV_RESET  = 15'h0000;
    localparam logic [8:0]  TRIM_RESET = 9'h000;
    localparam logic [3:0]  SEL_RESET  = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Base clock source codes.
    typedef enum logic [3:0] {
        SRC_SYSTEM    = 4'b0000,
        SRC_INSTR     = 4'b0001,
        SRC_PRIMARY   = 4'b0010,
        SRC_FAST_RC   = 4'b0011,
        SRC_LP_RC     = 4'b0100,
        SRC_SECONDARY = 4'b0101,
        SRC_PLL       = 4'b0110,
        SRC_EXT_REF   = 4'b1000
    } rcd_src_e;

    // Number of base source lines on the bus; the mux selects 8 of them, line 7 is unused.
    localparam int NUM_SRC = 9;

endpackage

// *** hdl/rcd_frac_gen.sv ***
`timescale 1ns/1ns
module rcd_frac_gen #(
    parameter int DIV_W  = 15,
    parameter int TRIM_W = 9
) (
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    // Settings and control.
    input  wire logic              run_i,
    input  wire logic [DIV_W-1:0]  divisor_i,
    input  wire logic [TRIM_W-1:0] trim_i,
    input  wire logic              base_tick_i,
    // Divided output and half-period boundary.
    output logic                   div_out_o,
    output logic                   half_done_o
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [DIV_W:0]    count_r;
    logic [TRIM_W-1:0] accum_r;
    logic [TRIM_W:0]   accum_sum;
    logic [DIV_W:0]    target;

    assign accum_sum = {1'b0, accum_r} + {1'b0, trim_i};
    // Half period is divisor cycles, plus one when the fraction carries out.
    assign target = {1'b0, divisor_i} + {{DIV_W{1'b0}}, accum_sum[TRIM_W]};
    assign half_done_o = run_i && base_tick_i && (count_r + 16'h0001 >= target);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= '0;
        end else if (!run_i || half_done_o) begin
            count_r <= '0;
        end else if (base_tick_i) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // Residue mod 512 carries N/512 cycle forward.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            accum_r <= '0;
        end else if (!run_i) begin
            accum_r <= '0;
        end else if (half_done_o) begin
            accum_r <= accum_sum[TRIM_W-1:0];
        end
    end

    // Each toggle ends a half period, so ratio is twice the divisor.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_out_o <= 1'b0;
        end else if (!run_i) begin
            div_out_o <= 1'b0;
        end else if (half_done_o) begin
            div_out_o <= ~div_out_o;
        end
    end

endmodule // rcd_frac_gen

// *** hdl/rcd_ref_divider.sv ***
`timescale 1ns/1ns
module rcd_ref_divider #(
    parameter int DIV_W  = 15,
    parameter int TRIM_W = 9
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Base clock sources, sampled as levels.
    input  wire logic [8:0]  base_src_i,
    // Reference output pin.
    output logic             ref_clock_out_o,
    output logic             ref_clock_out_oe_n_o
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [DIV_W-1:0]  half_period_divisor_r;
    logic [TRIM_W-1:0] fractional_trim_r;
    logic [DIV_W-1:0]  live_div_r;
    logic [TRIM_W-1:0] live_trim_r;
    logic              refclk_module_enable_r;
    logic              pin_drive_enable_r;
    logic              divider_update_request_r;
    logic              clock_request_active_r;
    logic [3:0]        base_source_select_r;
    logic [3:0]        live_sel_r;
    logic [8:0]        src_meta_r;
    logic [8:0]        src_sync_r;
    logic              base_level_r;
    logic              base_tick;
    logic              base_now;
    logic              div_out;
    logic              half_done;
    logic              bus_req;
    logic              bus_wr;
    logic              hit;
    logic              ref_level_r;
    logic              load_now;
    logic              wr_ctl;
    logic              wr_div;
    logic              wr_trim;
    logic [15:0]       ctl_word;
    logic [15:0]       div_word;
    logic [15:0]       trim_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Maps a select code onto a source line; reserved codes give a dead source.
    function automatic logic pick_src(input logic [3:0] sel, input logic [8:0] lines);
        logic v;
        v = 1'b0;
        case (sel)
            rcd_pkg::SRC_SYSTEM:    v = lines[0];
            rcd_pkg::SRC_INSTR:     v = lines[1];
            rcd_pkg::SRC_PRIMARY:   v = lines[2];
            rcd_pkg::SRC_FAST_RC:   v = lines[3];
            rcd_pkg::SRC_LP_RC:     v = lines[4];
            rcd_pkg::SRC_SECONDARY: v = lines[5];
            rcd_pkg::SRC_PLL:       v = lines[6];
            rcd_pkg::SRC_EXT_REF:   v = lines[8];
            default:                v = 1'b0;
        endcase
        return v;
    endfunction

    // Register decode shared by the answer, write and read logic.
    function automatic logic at_reg(input logic [3:0] adr, input logic [3:0] offset);
        return adr == offset;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Sources arrive from other clock domains, so each passes two flops first.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            src_meta_r <= '0;
            src_sync_r <= '0;
        end else begin
            src_meta_r <= base_src_i;
            src_sync_r <= src_meta_r;
        end
    end

    assign base_now = pick_src(live_sel_r, src_sync_r);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            base_level_r <= 1'b0;
        end else begin
            base_level_r <= base_now;
        end
    end

    // A base cycle is counted on each rising edge of the chosen source.
    // The source must run well below half of clk_i, or edges are lost in the synchroniser.
    assign base_tick = base_now && !base_level_r;

    ////////////////////////////////////////////////////////////////////////////////
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign bus_wr  = bus_req && wb_we_i;
    assign hit     = at_reg(wb_adr_i, rcd_pkg::ADDR_CONTROL)
                     || at_reg(wb_adr_i, rcd_pkg::ADDR_DIVISOR)
                     || at_reg(wb_adr_i, rcd_pkg::ADDR_TRIM);
    // Write strobes per register; a cycle answered with err never writes.
    assign wr_ctl  = bus_wr && at_reg(wb_adr_i, rcd_pkg::ADDR_CONTROL);
    assign wr_div  = bus_wr && at_reg(wb_adr_i, rcd_pkg::ADDR_DIVISOR);
    assign wr_trim = bus_wr && at_reg(wb_adr_i, rcd_pkg::ADDR_TRIM);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && hit;
            wb_err_o <= bus_req && !hit;
        end
    end

    // Software copies of divisor and trim; byte lanes follow sel.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            half_period_divisor_r <= rcd_pkg::DIV_RESET;
            fractional_trim_r     <= rcd_pkg::TRIM_RESET;
        end else if (wr_div) begin
            if (wb_sel_i[0]) begin
                half_period_divisor_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                half_period_divisor_r[14:8] <= wb_dat_i[14:8];
            end
        end else if (wr_trim) begin
            if (wb_sel_i[0]) begin
                fractional_trim_r[0] <= wb_dat_i[rcd_pkg::TRIM_LSB];
            end
            if (wb_sel_i[1]) begin
                fractional_trim_r[8:1] <= wb_dat_i[15:8];
            end
        end
    end

    // Control bits; the source select is frozen while the request is active.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            refclk_module_enable_r <= 1'b0;
            pin_drive_enable_r     <= 1'b0;
            base_source_select_r   <= rcd_pkg::SEL_RESET;
        end else if (wr_ctl) begin
            if (wb_sel_i[0] && !clock_request_active_r) begin
                base_source_select_r <= wb_dat_i[rcd_pkg::CTL_SEL_LSB +: rcd_pkg::SEL_W];
            end
            if (wb_sel_i[1]) begin
                refclk_module_enable_r <= wb_dat_i[rcd_pkg::CTL_ENABLE_BIT];
                pin_drive_enable_r     <= wb_dat_i[rcd_pkg::CTL_PIN_BIT];
            end
        end
    end

    // One load condition drives the request clear and the live copy, so they never disagree.
    assign load_now = divider_update_request_r
                      && (half_done || !clock_request_active_r || live_div_r == '0);

    // Request is set by software and cleared by hardware once applied.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            divider_update_request_r <= 1'b0;
        end else if (wr_ctl && wb_sel_i[1] && wb_dat_i[rcd_pkg::CTL_UPDATE_BIT]) begin
            divider_update_request_r <= 1'b1;
        end else if (load_now) begin
            divider_update_request_r <= 1'b0;
        end
    end

    // New settings load at a half-period boundary while dividing, or at once when inactive or on a zero divisor.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            live_div_r  <= rcd_pkg::DIV_RESET;
            live_trim_r <= rcd_pkg::TRIM_RESET;
        end else if (load_now) begin
            live_div_r  <= half_period_divisor_r;
            live_trim_r <= fractional_trim_r;
        end
    end

    // Active follows enable, but drops only once ref_level_r is low; by then enable has already forced the pin low.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clock_request_active_r <= 1'b0;
            live_sel_r             <= rcd_pkg::SEL_RESET;
        end else if (refclk_module_enable_r) begin
            clock_request_active_r <= 1'b1;
            if (!clock_request_active_r) begin
                live_sel_r <= base_source_select_r;
            end
        end else if (!ref_level_r) begin
            clock_request_active_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    rcd_frac_gen #(
        .DIV_W  (DIV_W),
        .TRIM_W (TRIM_W)
    ) u_gen (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .run_i       (clock_request_active_r),
        .divisor_i   (live_div_r),
        .trim_i      (live_trim_r),
        .base_tick_i (base_tick),
        .div_out_o   (div_out),
        .half_done_o (half_done)
    );

    // Zero divisor bypasses the divider and its trim entirely.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_level_r <= 1'b0;
        end else if (!clock_request_active_r) begin
            ref_level_r <= 1'b0;
        end else if (live_div_r == '0) begin
            ref_level_r <= base_now;
        end else begin
            ref_level_r <= div_out;
        end
    end

    // Clearing either enable forces the pin low at once, so a high phase may be cut short.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_clock_out_o <= 1'b0;
        end else begin
            ref_clock_out_o <= ref_level_r && refclk_module_enable_r
                               && pin_drive_enable_r;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_clock_out_oe_n_o <= 1'b1;
        end else begin
            ref_clock_out_oe_n_o <= !(refclk_module_enable_r && pin_drive_enable_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read words follow the field positions, so unimplemented bits stay zero.
    always_comb begin
        ctl_word = 16'h0000;
        ctl_word[rcd_pkg::CTL_ENABLE_BIT] = refclk_module_enable_r;
        ctl_word[rcd_pkg::CTL_PIN_BIT]    = pin_drive_enable_r;
        ctl_word[rcd_pkg::CTL_UPDATE_BIT] = divider_update_request_r;
        ctl_word[rcd_pkg::CTL_ACTIVE_BIT] = clock_request_active_r;
        ctl_word[rcd_pkg::CTL_SEL_LSB +: rcd_pkg::SEL_W] = base_source_select_r;
    end

    always_comb begin
        div_word = 16'h0000;
        div_word[DIV_W-1:0] = half_period_divisor_r;
    end

    always_comb begin
        trim_word = 16'h0000;
        trim_word[rcd_pkg::TRIM_LSB +: TRIM_W] = fractional_trim_r;
    end

    // Read data; unimplemented bits read as zero.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_we_i) begin
            if (at_reg(wb_adr_i, rcd_pkg::ADDR_CONTROL)) begin
                wb_dat_o <= {16'h0000, ctl_word};
            end else if (at_reg(wb_adr_i, rcd_pkg::ADDR_DIVISOR)) begin
                wb_dat_o <= {16'h0000, div_word};
            end else if (at_reg(wb_adr_i, rcd_pkg::ADDR_TRIM)) begin
                wb_dat_o <= {16'h0000, trim_word};
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

endmodule // rcd_ref_divider

// *** test/rcd_ref_divider_props.sv ***
`timescale 1ns/1ns
module rcd_ref_divider_props (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        wb_err_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    logic req;
    logic mapped;
    logic rd;
    logic we_q;
    always_ff @(posedge clk_i) begin
        we_q <= wb_we_i;
    end
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign rd = wb_ack_o && !we_q;
    assign mapped = (wb_adr_i == rcd_pkg::ADDR_CONTROL) || (wb_adr_i == rcd_pkg::ADDR_DIVISOR)
                 || (wb_adr_i == rcd_pkg::ADDR_TRIM);
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_req_answered: assert property (req |=> wb_ack_o || wb_err_o)
        else $error("request not answered in one cycle");
    a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    a_ack_err_apart: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    a_ack_mapped: assert property (wb_ack_o |-> $past(mapped))
        else $error("ack for unmapped address");
    a_err_unmapped: assert property (wb_err_o |-> !$past(mapped))
        else $error("err for mapped address");
    a_div_top_zero: assert property (rd && $past(wb_adr_i) == rcd_pkg::ADDR_DIVISOR
        |-> wb_dat_o[15] == 1'b0) else $error("divisor top bit read as one");
    a_trim_low_zero: assert property (rd && $past(wb_adr_i) == rcd_pkg::ADDR_TRIM
        |-> wb_dat_o[6:0] == 7'h00) else $error("trim low bits read as nonzero");
    a_read_data_hold: assert property ($changed(wb_dat_o) |-> rd)
        else $error("read data changed outside a read");
    c_read: cover property (rd);
    c_error: cover property (wb_err_o);
    c_write: cover property (req && wb_we_i);
endmodule // rcd_ref_divider_props

// *** test/tb.sv ***
`timescale 1ns/1ns
module tb;
    typedef struct {
        logic [15:0] dw;
        logic [15:0] tw;
        logic [15:0] dr;
        logic [15:0] tr;
        logic [15:0] per;
    } rcd_row_s;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        wb_err_o;
    logic        ref_clock_out_o;
    logic        ref_clock_out_oe_n_o;
    logic [8:0]  base_src_i = 9'h000;
    logic        slow = 1'b0;
    logic [2:0]  cnt = 3'h0;
    int          src_bit = 0;
    int          n_fail = 0;
    int          tests_run = 0;
    int          n;
    logic [15:0] q;
    logic        e;
    logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
    rcd_row_s    rows [6];
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Base source of 16 clk cycles, placed only on the bit under test.
    always @(posedge clk_i) begin
        cnt <= cnt + 3'h1;
        slow <= (cnt == 3'h7) ? ~slow : slow;
        base_src_i <= slow ? (9'h001 << src_bit) : 9'h000;
    end
    rcd_ref_divider i_rcd_ref_divider (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .base_src_i(base_src_i), .ref_clock_out_o(ref_clock_out_o),
        .ref_clock_out_oe_n_o(ref_clock_out_oe_n_o)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Tests run %0d, failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            close_out();
        end
        q = wb_dat_o[15:0];
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Polls by bus reads, so a stuck status bit costs a few hundred reads.
    task automatic wait_clear(input int b);
        int k;
        k = 0;
        do begin
            xfer(1'b0, rcd_pkg::ADDR_CONTROL, 16'h0000);
            k++;
        end while (q[b] !== 1'b0 && k < 300);
        check(q[b], 16'h0000);
        if (q[b] !== 1'b0) begin
            close_out();
        end
    endtask
    task automatic rise_wait(output int c);
        logic p;
        logic r;
        c = 0;
        p = ref_clock_out_o;
        do begin
            @(negedge clk_i);
            c++;
            r = (ref_clock_out_o === 1'b1) && (p === 1'b0);
            p = ref_clock_out_o;
        end while (!r && c < 3000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{16'hFFFF, 16'hFFFF, 16'h7FFF, 16'hFF80, 16'h0000};
        rows[1] = '{16'h0000, 16'hFF80, 16'h0000, 16'hFF80, 16'h0010};
        rows[2] = '{16'h0002, 16'h0000, 16'h0002, 16'h0000, 16'h0040};
        rows[3] = '{16'h0003, 16'h0000, 16'h0003, 16'h0000, 16'h0060};
        rows[4] = '{16'h0001, 16'h8000, 16'h0001, 16'h8000, 16'h0030};
        rows[5] = '{16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0020};
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        xfer(1'b0, rcd_pkg::ADDR_CONTROL, 16'h0000);
        check(q, 16'h0000);
        xfer(1'b0, rcd_pkg::ADDR_DIVISOR, 16'h0000);
        check(q, 16'h0000);
        xfer(1'b0, rcd_pkg::ADDR_TRIM, 16'h0000);
        check(q, 16'h0000);
        check(ref_clock_out_oe_n_o, 16'h0001);
        xfer(1'b0, 4'hC, 16'h0000);
        check(e, 16'h0001);
        $display("Test reset done");
        xfer(1'b1, rcd_pkg::ADDR_CONTROL, 16'h9000);
        for (int i = 0; i < 6; i++) begin
            xfer(1'b1, rcd_pkg::ADDR_DIVISOR, rows[i].dw);
            xfer(1'b1, rcd_pkg::ADDR_TRIM, rows[i].tw);
            xfer(1'b0, rcd_pkg::ADDR_DIVISOR, 16'h0000);
            check(q, rows[i].dr);
            xfer(1'b0, rcd_pkg::ADDR_TRIM, 16'h0000);
            check(q, rows[i].tr);
            if (rows[i].per != 16'h0000) begin
                xfer(1'b1, rcd_pkg::ADDR_CONTROL, 16'h9200);
                wait_clear(rcd_pkg::CTL_UPDATE_BIT);
                rise_wait(n);
                rise_wait(n);
                rise_wait(n);
                check(16'(n), rows[i].per);
            end
            $display("Test row %0d done", i);
        end
        check(ref_clock_out_oe_n_o, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, rcd_pkg::ADDR_CONTROL, 16'h0000);
            wait_clear(rcd_pkg::CTL_ACTIVE_BIT);
            src_bit <= int'(codes[i]);
            xfer(1'b1, rcd_pkg::ADDR_CONTROL, {12'h000, codes[i]});
            xfer(1'b1, rcd_pkg::ADDR_CONTROL, {12'h900, codes[i]});
            rise_wait(n);
            rise_wait(n);
            rise_wait(n);
            check(16'(n), 16'h0020);
        end
        $display("Test source codes done");
        xfer(1'b1, rcd_pkg::ADDR_CONTROL, 16'h9002);
        xfer(1'b0, rcd_pkg::ADDR_CONTROL, 16'h0000);
        check(q, 16'h9108);
        xfer(1'b1, rcd_pkg::ADDR_CONTROL, 16'h8008);
        repeat (4) @(negedge clk_i);
        check(ref_clock_out_oe_n_o, 16'h0001);
        xfer(1'b1, rcd_pkg::ADDR_CONTROL, 16'h0008);
        wait_clear(rcd_pkg::CTL_ACTIVE_BIT);
        src_bit <= 7;
        xfer(1'b1, rcd_pkg::ADDR_CONTROL, 16'h0007);
        xfer(1'b1, rcd_pkg::ADDR_CONTROL, 16'h9007);
        rise_wait(n);
        rise_wait(n);
        check(16'(n >= 3000), 16'h0001);
        $display("Test refused and reserved done");
        close_out();
    end
endmodule // tb
bind rcd_ref_divider rcd_ref_divider_props i_props (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o)
);
